/* File: hw/dpsram_pkg.sv */
// constants shared by the dual-port synchronous ram design
package dpsram_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int PORTS = 2;
  localparam int DEPTH = 65536;

  // ==========================================================
  // byte lane positions inside a data word
  localparam int LOWER_LANE = 0;
  localparam int UPPER_LANE = 1;

  // ==========================================================
  // counter and reset values
  localparam logic [ADDR_W-1:0] CLEAR_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [LANES-1:0] LANES_OFF = 2'h0;

  // ==========================================================
  // read output latency modes, as seen on the latency select pin
  localparam logic LAT_FLOW = 1'h0;
  localparam logic LAT_PIPE = 1'h1;

endpackage

/* File: hw/dpsram_mem.sv */
// shared storage array with two byte-lane write ports and two read ports
`timescale 1ns/1ns

module dpsram_mem #(
  parameter int ADDR_W = dpsram_pkg::ADDR_W,
  parameter int DATA_W = dpsram_pkg::DATA_W,
  parameter int LANE_W = dpsram_pkg::LANE_W,
  parameter int DEPTH = dpsram_pkg::DEPTH
) (
  input wire logic clk, // core clock
  input wire logic [1:0][ADDR_W-1:0] addr, // word address per port
  input wire logic [1:0][1:0] we, // lane write strobes per port
  input wire logic [1:0][DATA_W-1:0] wdata, // write data per port
  output logic [1:0][DATA_W-1:0] rdata // read data per port
);

  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // ==========================================================
  // writes: port 1 is applied last, so it wins an equal-address clash
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        if (we[p][l]) begin
          mem[addr[p]][l*LANE_W +: LANE_W] <= wdata[p][l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ==========================================================
  // reads: both ports see the one array
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rdata[p] = mem[addr[p]];
    end
  end

endmodule

/* File: hw/dpsram_top.sv */
// port logic of a two-port synchronous static ram with address counters
//
// Operation
// - 64K words of 18 bits, two ports
// - address, data, controls registered before use
// - per-port flow-through or pipelined read mode
// - pipelined read data one cycle later
// - chip selects: one stage flow, two pipelined
// - lane selects always one register stage
// - deselect floats data and enters standby
// - write only selected lanes, others kept
// - read drives selected lanes when output enabled
// - output enable acts asynchronously, floats lanes
// - counter clear forces address zero, highest priority
// - address load takes external address
// - count disabled reuses previous address
// - count enabled uses previous address plus one
// - load and clear ignore selects
// - counter advances even when deselected
// - write self-timed, no separate strobe
`timescale 1ns/1ns

module dpsram_top #(
  parameter int ADDR_W = dpsram_pkg::ADDR_W,
  parameter int DATA_W = dpsram_pkg::DATA_W,
  parameter int LANE_W = dpsram_pkg::LANE_W,
  parameter int DEPTH = dpsram_pkg::DEPTH
) (
  input wire logic CORE_CLK, // core clock, both ports
  input wire logic RST, // async reset, active high
  input wire logic [1:0] PRIMARY_SELECT_N, // chip select, low active
  input wire logic [1:0] SECONDARY_SELECT, // chip select, high active
  input wire logic [1:0] UPPER_LANE_SEL_N, // upper lane select
  input wire logic [1:0] LOWER_LANE_SEL_N, // lower lane select
  input wire logic [1:0] READ_WRITE_N, // high read, low write
  input wire logic [1:0] OUTPUT_EN_N, // async output enable
  input wire logic [1:0][ADDR_W-1:0] ADDR, // external address
  input wire logic [1:0] ADDR_LOAD_N, // load counter
  input wire logic [1:0] ADVANCE_EN_N, // count enable
  input wire logic [1:0] COUNT_CLEAR_N, // clear counter
  input wire logic [1:0] LATENCY_SELECT, // high pipelined
  input wire logic [1:0][DATA_W-1:0] DQ_I, // data pin input
  output logic [1:0][DATA_W-1:0] DQ_O, // data pin output
  output logic [1:0][1:0] DQ_OE, // lane drive enable
  output logic [1:0] STANDBY // port in low-power standby
);

  // ==========================================================
  // per-port state
  typedef struct packed {
    logic [ADDR_W-1:0] addr; // internal address in use
    logic sel1; // chip selects, first stage
    logic rd1; // read request, first stage
    logic [1:0] lane1; // lane selects, only stage
    logic [DATA_W-1:0] wdata; // captured write data
    logic wr1; // write request, first stage
    logic rd2; // selected read, second stage
    logic [DATA_W-1:0] pipe; // pipelined read holding stage
    logic [DATA_W-1:0] dq; // data driven on the pins
    logic [1:0] drive; // lanes holding read data
    logic standby; // port deselected
  } dpsram_port_t;

  localparam dpsram_port_t PORT_RST = '{
    addr: dpsram_pkg::ADDR_RST,
    sel1: 1'h0,
    rd1: 1'h0,
    lane1: dpsram_pkg::LANES_OFF,
    wdata: dpsram_pkg::DATA_RST,
    wr1: 1'h0,
    rd2: 1'h0,
    pipe: dpsram_pkg::DATA_RST,
    dq: dpsram_pkg::DATA_RST,
    drive: dpsram_pkg::LANES_OFF,
    standby: 1'h1
  };

  logic [1:0][ADDR_W-1:0] mem_addr;
  logic [1:0][1:0] mem_we;
  logic [1:0][DATA_W-1:0] mem_wdata;
  logic [1:0][DATA_W-1:0] mem_rdata;

  // ==========================================================
  // shared storage
  dpsram_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .LANE_W(LANE_W),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk(CORE_CLK),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // one copy of the port logic for each port
  for (genvar p = 0; p < dpsram_pkg::PORTS; p++) begin : g_port
    dpsram_port_t port_r;
    dpsram_port_t port_nxt;
    logic selected;
    logic [ADDR_W-1:0] count_nxt;

    // chip selects sampled at this edge
    assign selected = ~PRIMARY_SELECT_N[p] & SECONDARY_SELECT[p];

    // address counter, independent of selects
    always_comb begin
      if (!COUNT_CLEAR_N[p]) begin
        count_nxt = dpsram_pkg::CLEAR_ADDR;
      end else if (!ADDR_LOAD_N[p]) begin
        count_nxt = ADDR[p];
      end else if (!ADVANCE_EN_N[p]) begin
        // width of the counter makes the top address wrap to zero
        count_nxt = port_r.addr + dpsram_pkg::ADDR_STEP;
      end else begin
        count_nxt = port_r.addr;
      end
    end

    // storage access works from the registered request
    assign mem_addr[p] = port_r.addr;
    assign mem_wdata[p] = port_r.wdata;
    // write lands at the next edge, no strobe needed from outside
    assign mem_we[p] = port_r.wr1 ? port_r.lane1 : dpsram_pkg::LANES_OFF;

    always_comb begin
      port_nxt = port_r;
      // input registers
      port_nxt.addr = count_nxt;
      port_nxt.sel1 = selected;
      port_nxt.rd1 = READ_WRITE_N[p];
      port_nxt.lane1 = ~{UPPER_LANE_SEL_N[p], LOWER_LANE_SEL_N[p]};
      port_nxt.wdata = DQ_I[p];
      port_nxt.wr1 = selected & ~READ_WRITE_N[p];
      port_nxt.standby = ~selected;
      // second chip-select stage for pipelined reads
      port_nxt.rd2 = port_r.sel1 & port_r.rd1;
      port_nxt.pipe = mem_rdata[p];
      if (LATENCY_SELECT[p] == dpsram_pkg::LAT_PIPE) begin
        // data and chip selects one stage later, lanes still one stage
        port_nxt.dq = port_r.pipe;
        port_nxt.drive = port_r.rd2 ? port_r.lane1 : dpsram_pkg::LANES_OFF;
      end else begin
        port_nxt.dq = mem_rdata[p];
        port_nxt.drive = (port_r.sel1 & port_r.rd1) ? port_r.lane1 : dpsram_pkg::LANES_OFF;
      end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
        port_r <= PORT_RST;
      end else begin
        port_r <= port_nxt;
      end
    end

    assign DQ_O[p] = port_r.dq;
    assign STANDBY[p] = port_r.standby;
    // output enable gates the lanes without waiting for a clock
    assign DQ_OE[p] = OUTPUT_EN_N[p] ? dpsram_pkg::LANES_OFF : port_r.drive;
  end

endmodule

/* File: testbench/dpsram_chk_assertions.sv */
// pin assertions for the dual-port ram
`timescale 1ns/1ns
module dpsram_chk (
  input wire logic CORE_CLK, // clock
  input wire logic RST, // reset
  input wire logic [1:0] PRIMARY_SELECT_N, // cs
  input wire logic [1:0] SECONDARY_SELECT, // cs
  input wire logic [1:0] UPPER_LANE_SEL_N, // lane
  input wire logic [1:0] LOWER_LANE_SEL_N, // lane
  input wire logic [1:0] READ_WRITE_N, // dir
  input wire logic [1:0] OUTPUT_EN_N, // oe
  input wire logic [1:0] LATENCY_SELECT, // mode
  input wire logic [1:0][1:0] DQ_OE, // drive
  input wire logic [1:0] STANDBY // idle
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ========================================
  // port 0 stays flow-through, port 1 ends pipelined
  chk_oe_float: assert property ((OUTPUT_EN_N[0] |-> !DQ_OE[0]) and
    (OUTPUT_EN_N[1] |-> !DQ_OE[1])) else $error("drive with oe off");
  chk_desel_idle: assert property ((PRIMARY_SELECT_N[0] ||
    !SECONDARY_SELECT[0]) |=> STANDBY[0]) else $error("no standby");
  chk_sel_awake: assert property ((!PRIMARY_SELECT_N[0] &&
    SECONDARY_SELECT[0]) |=> !STANDBY[0]) else $error("stuck standby");
  chk_flow_desel: assert property (PRIMARY_SELECT_N[0] |-> ##2
    !DQ_OE[0]) else $error("flow deselect");
  chk_pipe_desel: assert property ((LATENCY_SELECT[1] &&
    PRIMARY_SELECT_N[1]) |-> ##3 !DQ_OE[1]) else $error("pipe deselect");
  chk_upper_lane: assert property (UPPER_LANE_SEL_N[1] |-> ##2
    !DQ_OE[1][1]) else $error("upper lane");
  chk_write_quiet: assert property (!READ_WRITE_N[0] |-> ##2
    !DQ_OE[0]) else $error("drive on write");
  chk_read_drive: assert property ((!PRIMARY_SELECT_N[0] &&
    SECONDARY_SELECT[0] && READ_WRITE_N[0] && !UPPER_LANE_SEL_N[0] &&
    !LOWER_LANE_SEL_N[0]) |-> ##2 (DQ_OE[0] == 2'h3 || OUTPUT_EN_N[0]))
    else $error("no read drive");
endmodule
bind dpsram_top dpsram_chk i_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .PRIMARY_SELECT_N(PRIMARY_SELECT_N), .SECONDARY_SELECT(SECONDARY_SELECT),
  .UPPER_LANE_SEL_N(UPPER_LANE_SEL_N), .LOWER_LANE_SEL_N(LOWER_LANE_SEL_N),
  .READ_WRITE_N(READ_WRITE_N), .OUTPUT_EN_N(OUTPUT_EN_N),
  .LATENCY_SELECT(LATENCY_SELECT), .DQ_OE(DQ_OE), .STANDBY(STANDBY));

/* File: testbench/dpsram_wire.sv */
// master-side model of one port's data pins
`timescale 1ns/1ns
module dpsram_wire (
  input wire logic clk, // clock
  input wire logic mdrv, // master drives pins
  input wire logic [17:0] md, // master data
  input wire logic [17:0] dq_o, // device data
  input wire logic [1:0] dq_oe, // device lane drive
  output logic [17:0] lvl // pin level
);
  logic [17:0] last_r = 18'h00000;
  always_comb begin
    lvl = mdrv ? md : ~last_r;
    if (dq_oe[1]) lvl[17:9] = dq_o[17:9];
    if (dq_oe[0]) lvl[8:0] = dq_o[8:0];
  end
  always @(posedge clk) last_r <= lvl;
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the dual-port ram port logic
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cs_n = 2'h3, cs2 = 2'h3, ub_n = 2'h0, lb_n = 2'h0, sb;
  logic [1:0] rw_n = 2'h3, oe_n = 2'h0, ld_n = 2'h3, adv_n = 2'h3;
  logic [1:0] clr_n = 2'h3, lat = 2'h0, mdrv = 2'h0;
  logic [1:0][15:0] addr = 32'h0;
  logic [1:0][17:0] md = 36'h0, dqi, dqo;
  logic [1:0][1:0] oe;
  int bad_count = 0, total_checks = 0, cycles = 0;
  always #25 clk = ~clk;
  dpsram_top i_dut (.CORE_CLK(clk), .RST(rst), .PRIMARY_SELECT_N(cs_n),
    .SECONDARY_SELECT(cs2), .UPPER_LANE_SEL_N(ub_n), .LOWER_LANE_SEL_N(lb_n),
    .READ_WRITE_N(rw_n), .OUTPUT_EN_N(oe_n), .ADDR(addr), .ADDR_LOAD_N(ld_n),
    .ADVANCE_EN_N(adv_n), .COUNT_CLEAR_N(clr_n), .LATENCY_SELECT(lat),
    .DQ_I(dqi), .DQ_O(dqo), .DQ_OE(oe), .STANDBY(sb));
  for (genvar p = 0; p < 2; p++) begin : g_w
    dpsram_wire i_w (.clk(clk), .mdrv(mdrv[p]), .md(md[p]), .dq_o(dqo[p]),
      .dq_oe(oe[p]), .lvl(dqi[p]));
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [17:0] e, v);
    total_checks++;
    if (v !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one access cycle then one idle cycle; c is {load_n, advance_n, clear_n}
  task automatic acc(input int p, input logic r, input logic [1:0] ln,
      input logic [2:0] c, input logic [15:0] a, input logic [17:0] d);
    cs_n[p] = 1'b0;
    rw_n[p] = r;
    {ub_n[p], lb_n[p]} = ln;
    {ld_n[p], adv_n[p], clr_n[p]} = c;
    addr[p] = a;
    md[p] = d;
    mdrv[p] = ~r;
    step(1);
    cs_n[p] = 1'b1;
    {ld_n[p], adv_n[p], clr_n[p]} = 3'h7;
    mdrv[p] = 1'b0;
    step(1);
  endtask
  task automatic rd(input int p, input logic [1:0] ln, input logic [15:0] a,
      input logic [17:0] e);
    logic [17:0] m;
    m = {{9{~ln[1]}}, {9{~ln[0]}}};
    acc(p, 1'b1, ln, 3'h3, a, 18'h0);
    if (lat[p]) begin
      chk("early drive", 18'h0, 18'(oe[p]));
      step(1);
    end
    chk("read data", e & m, dqo[p] & m);
    chk("lane drive", {16'h0000, ~ln}, 18'(oe[p]));
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      results;
    end
  end
  initial begin
    step(12);
    rst = 1'b0;
    chk("standby", 18'h3, 18'(sb));
    step(1);
    acc(0, 1'b0, 2'h0, 3'h3, 16'h1234, 18'h2A5C3);
    rd(1, 2'h0, 16'h1234, 18'h2A5C3);
    acc(0, 1'b0, 2'h1, 3'h3, 16'h1234, 18'h15555);
    rd(0, 2'h0, 16'h1234, 18'h155C3);
    rd(1, 2'h2, 16'h1234, 18'h155C3);
    $display("test lanes done");
    acc(0, 1'b0, 2'h0, 3'h3, 16'hFFFF, 18'h3FFFF);
    acc(0, 1'b0, 2'h0, 3'h5, 16'h1234, 18'h00011);
    rd(1, 2'h0, 16'hFFFF, 18'h3FFFF);
    rd(1, 2'h0, 16'h0000, 18'h00011);
    // second select low: no write, but the counter still loads
    cs2[0] = 1'b0;
    acc(0, 1'b0, 2'h0, 3'h3, 16'hFFFF, 18'h00000);
    cs2[0] = 1'b1;
    acc(0, 1'b1, 2'h0, 3'h7, 16'h0000, 18'h0);
    chk("held read", 18'h3FFFF, dqo[0]);
    // let the read drive end before the next write takes the pins
    step(1);
    acc(0, 1'b0, 2'h0, 3'h2, 16'h0005, 18'h00022);
    acc(0, 1'b0, 2'h0, 3'h5, 16'h0005, 18'h00033);
    adv_n[0] = 1'b0;
    step(1);
    acc(0, 1'b0, 2'h0, 3'h7, 16'h0005, 18'h00044);
    for (int i = 0; i < 3; i++) rd(1, 2'h0, 16'(i), 18'(i * 17 + 34));
    $display("test counter done");
    lat[1] = 1'b1;
    step(2);
    rd(1, 2'h0, 16'h1234, 18'h155C3);
    rd(1, 2'h2, 16'h1234, 18'h155C3);
    acc(1, 1'b1, 2'h0, 3'h3, 16'h1234, 18'h0);
    step(1);
    chk("oe drive", 18'h3, 18'(oe[1]));
    oe_n[1] = 1'b1;
    #1;
    chk("oe float", 18'h0, 18'(oe[1]));
    step(1);
    oe_n[1] = 1'b0;
    $display("test pipeline done");
    results;
  end
endmodule
